// ===== rtl/mpf_pin_mux.sv
// pin function select for the multiplexed pads of the processor
// assumes peripherals share the clock; pads and straps are asynchronous and synchronised here
// Contract
// R1: exactly 24 pads carry selectable functions
// R2: chip selects 5..2 serve sdram or rom
// R3: enabled channel's controller drives its chip select
// R4: both enabled: select asserts in both cycles
// R5: dma pair 1 can be chip selects 7,6
// R6: pci request/grant roles follow boot arbiter mode
// R7: internal arbiter: requests in, grants out
// R8: external arbiter: request 0 outputs pci request
// R9: external arbiter: grant 0 inputs pci grant
// R10: external arbiter: request 1 is interrupt output
// R11: external arbiter: other request/grant pads unused
// R12: other pads follow configuration bits, pairwise
// R13: debugger enable plus configuration own serial-1 handshake
// R14: serial-0 handshake pads always feed interrupts
// R15: software keeps those interrupts off when serial
// R16: request 3: parallel 15, dma, timer 1
// R17: ack 3 / request 2 parallel, dma, timer
// R18: done pad: parallel 7, dma done, timer 0
// R19: cts 1: parallel 2, cts, debug serial
// R20: rts 1: parallel 1, rts, sgram, trace
// R21: parallel bit 0 dedicated; others shared
// R22: combinational select, deselected inputs read inactive; pads and core outputs are registered, one cycle after the select
// R23: configuration clears to zero on reset
`timescale 1ns/100ps
module mpf_pin_mux (
   input  wire logic                         clock,
   input  wire logic                         rst,
   input  wire mpf_pkg::mpf_from_core_s      core_in,
   output mpf_pkg::mpf_to_core_s             core_out,
   input  wire logic [mpf_pkg::PAD_W-1:0]    pad_in,
   output logic      [mpf_pkg::PAD_W-1:0]    pad_out,
   output logic      [mpf_pkg::PAD_W-1:0]    pad_oe,
   input  wire logic                         debugger_enable_n,
   input  wire logic                         ext_arb_strap,
   input  wire logic                         cfg_wr_en,
   input  wire logic [mpf_pkg::CFG_W-1:0]    cfg_wr_data,
   output logic      [mpf_pkg::CFG_W-1:0]    pin_config_reg,
   output logic                              ext_arb_mode
);

   logic [mpf_pkg::SYNC_W-1:0] sync_q;         // synchronised pads, debug enable, strap
   logic [mpf_pkg::PAD_W-1:0]  pad_s;          // synchronised pad levels
   logic                       dbg_n_s;        // synchronised debugger enable
   logic                       strap_s;        // synchronised arbiter strap
   logic [mpf_pkg::CFG_W-1:0]  cfg;            // shorthand for the register
   logic [mpf_pkg::PAD_W-1:0]  nxt_pad_out;
   logic [mpf_pkg::PAD_W-1:0]  nxt_pad_oe;
   logic [mpf_pkg::PAD_W-1:0]  par_sel;        // pad handed to the parallel port
   mpf_pkg::mpf_to_core_s      nxt_core;

   // every asynchronous input crosses two flops before any select logic sees it
   mpf_sync #(
      .W (mpf_pkg::SYNC_W)
   ) u_sync (
      .clock (clock),
      .d     ({ext_arb_strap, debugger_enable_n, pad_in}),
      .q     (sync_q)
   );

   assign pad_s   = sync_q[mpf_pkg::PAD_W-1:0];
   assign dbg_n_s = sync_q[mpf_pkg::PAD_W];
   assign strap_s = sync_q[mpf_pkg::PAD_W+1];
   assign cfg     = pin_config_reg;

   // chip select for one memory channel: {drive, level}; both owners may pull it low
   function automatic logic [1:0] cs_drive(input int ch, input mpf_pkg::mpf_from_core_s c);
      logic on;
      logic lvl;
      on  = c.sdram_en[ch] | c.rom_en[ch];
      lvl = ~((c.sdram_en[ch] & ~c.sdram_chip_select[ch]) |
              (c.rom_en[ch] & ~c.rom_chip_select[ch]));
      return {on, lvl};
   endfunction

   // pin configuration register, software written
   always_ff @(posedge clock) begin
      if (rst) begin
         pin_config_reg <= mpf_pkg::CFG_RST;                        // [R23]
      end else if (cfg_wr_en) begin
         pin_config_reg <= cfg_wr_data;                             // [R12]
      end
   end

   // arbiter mode is caught while reset is held, so it is a boot-time choice only
   always_ff @(posedge clock) begin
      if (rst) begin
         ext_arb_mode <= strap_s;                                   // [R6]
      end
   end

   // pad selection from the registered configuration
   always_comb begin
      logic [1:0] cs;
      cs          = 2'h0;
      nxt_pad_out = '1;
      nxt_pad_oe  = '0;
      par_sel     = '0;
      nxt_core    = mpf_pkg::CORE_IDLE;                             // [R22]

      // shared chip selects for channels 2..5, held high while no owner
      for (int ch = 2; ch <= 5; ch++) begin
         cs = cs_drive(ch, core_in);                                // [R2] [R3] [R4]
         nxt_pad_out[mpf_pkg::PAD_CS_LO+ch-2] = cs[0];
         nxt_pad_oe[mpf_pkg::PAD_CS_LO+ch-2]  = 1'b1;
      end

      // pci request and grant pads by boot mode
      if (!ext_arb_mode) begin
         nxt_core.arb_req_n = {pad_s[mpf_pkg::PAD_REQ3], pad_s[mpf_pkg::PAD_REQ2],
                               pad_s[mpf_pkg::PAD_REQ1], pad_s[mpf_pkg::PAD_REQ0]}; // [R7]
         nxt_pad_out[mpf_pkg::PAD_GNT0] = core_in.arb_gnt_n[0];
         nxt_pad_out[mpf_pkg::PAD_GNT1] = core_in.arb_gnt_n[1];
         nxt_pad_out[mpf_pkg::PAD_GNT2] = core_in.arb_gnt_n[2];
         nxt_pad_out[mpf_pkg::PAD_GNT3] = core_in.arb_gnt_n[3];
         nxt_pad_oe[mpf_pkg::PAD_GNT0]  = 1'b1;                     // [R7]
         nxt_pad_oe[mpf_pkg::PAD_GNT1]  = 1'b1;
         nxt_pad_oe[mpf_pkg::PAD_GNT2]  = 1'b1;
         nxt_pad_oe[mpf_pkg::PAD_GNT3]  = 1'b1;
      end else begin
         nxt_pad_out[mpf_pkg::PAD_REQ0] = core_in.pci_req_n;        // [R8]
         nxt_pad_oe[mpf_pkg::PAD_REQ0]  = 1'b1;
         nxt_core.pci_gnt_n             = pad_s[mpf_pkg::PAD_GNT0]; // [R9]
         nxt_pad_out[mpf_pkg::PAD_REQ1] = core_in.ext_arbiter_irq_out; // [R10]
         nxt_pad_oe[mpf_pkg::PAD_REQ1]  = 1'b1;
         // spare requests drive inactive high, spare grants are ignored inputs
         nxt_pad_oe[mpf_pkg::PAD_REQ2]  = 1'b1;                     // [R11]
         nxt_pad_oe[mpf_pkg::PAD_REQ3]  = 1'b1;
      end

      // request/acknowledge pair 3: dma wins, else timers, else parallel
      if (cfg[mpf_pkg::CFG_SEL_DMA3]) begin
         nxt_core.dma_request_in[3]     = pad_s[mpf_pkg::PAD_DRQ3];
         nxt_pad_out[mpf_pkg::PAD_DAK3] = core_in.dma_ack_out[3];
         nxt_pad_oe[mpf_pkg::PAD_DAK3]  = 1'b1;
      end else begin
         if (cfg[mpf_pkg::CFG_SEL_TMR1]) begin
            nxt_pad_out[mpf_pkg::PAD_DRQ3] = core_in.timer_out[1];  // [R16]
            nxt_pad_oe[mpf_pkg::PAD_DRQ3]  = 1'b1;
         end else begin
            par_sel[mpf_pkg::PAD_DRQ3] = 1'b1;
         end
         if (cfg[mpf_pkg::CFG_SEL_TMR0]) begin
            nxt_pad_out[mpf_pkg::PAD_DAK3] = core_in.timer_out[0];  // [R17]
            nxt_pad_oe[mpf_pkg::PAD_DAK3]  = 1'b1;
         end else begin
            par_sel[mpf_pkg::PAD_DAK3] = 1'b1;
         end
      end

      // pair 2: dma, or timer clock on the request pad
      if (cfg[mpf_pkg::CFG_SEL_DMA2]) begin
         nxt_core.dma_request_in[2]     = pad_s[mpf_pkg::PAD_DRQ2]; // [R17]
         nxt_pad_out[mpf_pkg::PAD_DAK2] = core_in.dma_ack_out[2];
         nxt_pad_oe[mpf_pkg::PAD_DAK2]  = 1'b1;
      end else begin
         if (cfg[mpf_pkg::CFG_SEL_TIMER_CLOCK_IN]) begin
            nxt_core.timer_clock_in = pad_s[mpf_pkg::PAD_DRQ2];     // [R17]
         end else begin
            par_sel[mpf_pkg::PAD_DRQ2] = 1'b1;
         end
         par_sel[mpf_pkg::PAD_DAK2] = 1'b1;
      end

      // pair 1: an enabled chip select 7/6 takes its pad before dma or parallel
      for (int ch = 6; ch <= 7; ch++) begin
         cs = cs_drive(ch, core_in);
         if (cs[1]) begin
            nxt_pad_out[(ch == 7) ? mpf_pkg::PAD_DRQ1 : mpf_pkg::PAD_DAK1] = cs[0]; // [R5]
            nxt_pad_oe[(ch == 7) ? mpf_pkg::PAD_DRQ1 : mpf_pkg::PAD_DAK1]  = 1'b1;
         end else if (!cfg[mpf_pkg::CFG_SEL_DMA1]) begin
            par_sel[(ch == 7) ? mpf_pkg::PAD_DRQ1 : mpf_pkg::PAD_DAK1] = 1'b1;
         end else if (ch == 7) begin
            nxt_core.dma_request_in[1] = pad_s[mpf_pkg::PAD_DRQ1];
         end else begin
            nxt_pad_out[mpf_pkg::PAD_DAK1] = core_in.dma_ack_out[1];
            nxt_pad_oe[mpf_pkg::PAD_DAK1]  = 1'b1;
         end
      end

      // pair 0: dma or parallel
      if (cfg[mpf_pkg::CFG_SEL_DMA0]) begin
         nxt_core.dma_request_in[0]     = pad_s[mpf_pkg::PAD_DRQ0]; // [R12]
         nxt_pad_out[mpf_pkg::PAD_DAK0] = core_in.dma_ack_out[0];
         nxt_pad_oe[mpf_pkg::PAD_DAK0]  = 1'b1;
      end else begin
         par_sel[mpf_pkg::PAD_DRQ0] = 1'b1;
         par_sel[mpf_pkg::PAD_DAK0] = 1'b1;
      end

      // done pad: timer output has priority, dma done is two-way
      if (cfg[mpf_pkg::CFG_SEL_DNTMR]) begin
         nxt_pad_out[mpf_pkg::PAD_DONE] = core_in.timer_out[0];     // [R18]
         nxt_pad_oe[mpf_pkg::PAD_DONE]  = 1'b1;
      end else if (cfg[mpf_pkg::CFG_SEL_DONE]) begin
         nxt_pad_out[mpf_pkg::PAD_DONE] = core_in.done_out_n;       // [R18]
         nxt_pad_oe[mpf_pkg::PAD_DONE]  = core_in.done_oe;
         nxt_core.done_in_n             = pad_s[mpf_pkg::PAD_DONE];
      end else begin
         par_sel[mpf_pkg::PAD_DONE] = 1'b1;
      end

      // serial data pairs
      for (int p = 0; p < 2; p++) begin
         if (cfg[mpf_pkg::CFG_SEL_SIO0+p]) begin
            nxt_core.rxd[p] = pad_s[(p == 1) ? mpf_pkg::PAD_RXD1 : mpf_pkg::PAD_RXD0]; // [R12]
            nxt_pad_out[(p == 1) ? mpf_pkg::PAD_TXD1 : mpf_pkg::PAD_TXD0] = core_in.txd[p];
            nxt_pad_oe[(p == 1) ? mpf_pkg::PAD_TXD1 : mpf_pkg::PAD_TXD0]  = 1'b1;
         end else begin
            par_sel[(p == 1) ? mpf_pkg::PAD_RXD1 : mpf_pkg::PAD_RXD0] = 1'b1;
            par_sel[(p == 1) ? mpf_pkg::PAD_TXD1 : mpf_pkg::PAD_TXD0] = 1'b1;
         end
      end

      // serial 1 handshake: an attached debugger takes both pads first
      if (!dbg_n_s) begin
         nxt_pad_out[mpf_pkg::PAD_CTS1] = core_in.debug_serial_out; // [R13] [R19]
         nxt_pad_oe[mpf_pkg::PAD_CTS1]  = 1'b1;
         nxt_pad_out[mpf_pkg::PAD_RTS1] = core_in.trace_status_out; // [R13] [R20]
         nxt_pad_oe[mpf_pkg::PAD_RTS1]  = 1'b1;
      end else begin
         if (cfg[mpf_pkg::CFG_SEL_HS1]) begin
            nxt_core.cts_n[1] = pad_s[mpf_pkg::PAD_CTS1];           // [R19]
         end else begin
            par_sel[mpf_pkg::PAD_CTS1] = 1'b1;
         end
         if (cfg[mpf_pkg::CFG_SEL_SGRAM]) begin
            nxt_pad_out[mpf_pkg::PAD_RTS1] = core_in.sgram_special_function; // [R20]
            nxt_pad_oe[mpf_pkg::PAD_RTS1]  = 1'b1;
         end else if (cfg[mpf_pkg::CFG_SEL_HS1]) begin
            nxt_pad_out[mpf_pkg::PAD_RTS1] = core_in.rts_n[1];      // [R20]
            nxt_pad_oe[mpf_pkg::PAD_RTS1]  = 1'b1;
         end else begin
            par_sel[mpf_pkg::PAD_RTS1] = 1'b1;
         end
      end

      // serial 0 handshake pads reach the interrupt inputs whatever is chosen;
      // software must mask them, every edge would interrupt otherwise
      nxt_core.irq_in = {pad_s[mpf_pkg::PAD_CTS0], pad_s[mpf_pkg::PAD_RTS0]}; // [R14] [R15]
      if (cfg[mpf_pkg::CFG_SEL_HS0]) begin
         nxt_core.cts_n[0]              = pad_s[mpf_pkg::PAD_CTS0];
         nxt_pad_out[mpf_pkg::PAD_RTS0] = core_in.rts_n[0];
         nxt_pad_oe[mpf_pkg::PAD_RTS0]  = 1'b1;
      end

      // parallel port takes every pad left to it; bit 0 always
      par_sel[mpf_pkg::PAD_PAR0] = 1'b1;                            // [R21]
      for (int b = 0; b < mpf_pkg::PAR_W; b++) begin
         if (par_sel[mpf_pkg::PAR_PAD[b]]) begin
            nxt_pad_out[mpf_pkg::PAR_PAD[b]] = core_in.par_out[b];  // [R21]
            nxt_pad_oe[mpf_pkg::PAR_PAD[b]]  = core_in.par_oe[b];
            nxt_core.par_in[b]               = pad_s[mpf_pkg::PAR_PAD[b]];
         end
      end
   end

   // output stage: pads float and peripherals see idle levels during reset
   always_ff @(posedge clock) begin
      if (rst) begin
         pad_out  <= '1;
         pad_oe   <= '0;
         core_out <= mpf_pkg::CORE_IDLE;
      end else begin
         pad_out  <= nxt_pad_out;                                   // [R22]
         pad_oe   <= nxt_pad_oe;
         core_out <= nxt_core;
      end
   end

   // checks
   a_mux_pin_count: assert property (@(posedge clock) // [R1]
      mpf_pkg::MUX_PINS == mpf_pkg::PAD_REQ2)
      else $error("multiplexed pad count is not 24");

   a_cs_conflict: assert property (@(posedge clock) disable iff (rst) // [R4]
      core_in.sdram_en[3] && core_in.rom_en[3] && !core_in.rom_chip_select[3]
      |=> pad_oe[mpf_pkg::PAD_CS_LO+1] && !pad_out[mpf_pkg::PAD_CS_LO+1])
      else $error("chip select 3 missed a rom cycle while both enabled");

   a_cs_owner: assert property (@(posedge clock) disable iff (rst) // [R3]
      core_in.sdram_en[3] && !core_in.rom_en[3]
      |=> pad_out[mpf_pkg::PAD_CS_LO+1] == $past(core_in.sdram_chip_select[3]))
      else $error("chip select 3 not following sdram owner");

   a_cs7_takes: assert property (@(posedge clock) disable iff (rst) // [R5]
      core_in.sdram_en[7] && !core_in.rom_en[7]
      |=> pad_oe[mpf_pkg::PAD_DRQ1]
      && pad_out[mpf_pkg::PAD_DRQ1] == $past(core_in.sdram_chip_select[7]))
      else $error("chip select 7 not on dma request 1 pad");

   a_int_arb_dirs: assert property (@(posedge clock) disable iff (rst) // [R7]
      !ext_arb_mode |=> !pad_oe[mpf_pkg::PAD_REQ0] && pad_oe[mpf_pkg::PAD_GNT3]
      && pad_out[mpf_pkg::PAD_GNT0] == $past(core_in.arb_gnt_n[0]))
      else $error("internal arbiter pad directions wrong");

   a_ext_req_out: assert property (@(posedge clock) disable iff (rst) // [R8]
      ext_arb_mode |=> pad_oe[mpf_pkg::PAD_REQ0]
      && pad_out[mpf_pkg::PAD_REQ0] == $past(core_in.pci_req_n))
      else $error("external arbiter request 0 not driven");

   a_ext_gnt_in: assert property (@(posedge clock) disable iff (rst) // [R9]
      ext_arb_mode |=> !pad_oe[mpf_pkg::PAD_GNT0]
      && core_out.pci_gnt_n == $past(pad_s[mpf_pkg::PAD_GNT0]))
      else $error("external grant 0 not delivered");

   a_ext_irq_out: assert property (@(posedge clock) disable iff (rst) // [R10]
      ext_arb_mode |=> pad_out[mpf_pkg::PAD_REQ1] == $past(core_in.ext_arbiter_irq_out))
      else $error("request 1 pad not carrying interrupt level");

   a_ext_unused: assert property (@(posedge clock) disable iff (rst) // [R11]
      ext_arb_mode |=> core_out.arb_req_n == 4'hF && pad_oe[mpf_pkg::PAD_REQ2]
      && !pad_oe[mpf_pkg::PAD_GNT1])
      else $error("spare pci pads not idle in external mode");

   a_debug_owns: assert property (@(posedge clock) disable iff (rst) // [R13]
      !dbg_n_s |=> pad_oe[mpf_pkg::PAD_CTS1]
      && pad_out[mpf_pkg::PAD_RTS1] == $past(core_in.trace_status_out))
      else $error("debugger does not own serial 1 handshake pads");

   a_irq_routed: assert property (@(posedge clock) disable iff (rst) // [R14]
      1'b1 |=> core_out.irq_in == $past({pad_s[mpf_pkg::PAD_CTS0], pad_s[mpf_pkg::PAD_RTS0]}))
      else $error("serial 0 handshake pads not at interrupt inputs");

   a_timer1_pad: assert property (@(posedge clock) disable iff (rst) // [R16]
      !cfg[mpf_pkg::CFG_SEL_DMA3] && cfg[mpf_pkg::CFG_SEL_TMR1]
      |=> pad_oe[mpf_pkg::PAD_DRQ3] && core_out.par_in[15] && !core_out.dma_request_in[3])
      else $error("request 3 pad not given to timer 1");

   a_cfg_reset: assert property (@(posedge clock) disable iff (rst) // [R23]
      $fell(rst) |-> pin_config_reg == mpf_pkg::CFG_RST && !pad_oe[mpf_pkg::PAD_CS_LO])
      else $error("configuration not cleared by reset");

endmodule

// ===== shared/mpf_pkg.sv
// constants, pad map and core bundles for the multiplexed pin function select block
// assumes one 10 MHz system clock; pads are split into in, out and output enable
package mpf_pkg;

   // system clock period, for reference only: this block has no timed waits
   localparam int CLK_PERIOD_NS = 100;

   // pad counts
   localparam int MUX_PINS = 24;               // pads with more than one function
   localparam int PAD_W    = 30;               // mux pads, fixed pci pads, parallel bit 0
   localparam int PAR_W    = 16;               // parallel port width
   localparam int SYNC_W   = 32;               // pads plus debugger enable plus boot strap

   // pad positions in the pad vectors
   localparam int PAD_CS_LO = 0;               // shared chip selects, channel 2 at 0 to 5 at 3
   localparam int PAD_GNT0  = 4;
   localparam int PAD_REQ0  = 5;
   localparam int PAD_REQ1  = 6;
   localparam int PAD_DRQ3  = 7;
   localparam int PAD_DAK3  = 8;
   localparam int PAD_DRQ2  = 9;
   localparam int PAD_DAK2  = 10;
   localparam int PAD_DRQ1  = 11;
   localparam int PAD_DAK1  = 12;
   localparam int PAD_DRQ0  = 13;
   localparam int PAD_DAK0  = 14;
   localparam int PAD_DONE  = 15;
   localparam int PAD_RXD1  = 16;
   localparam int PAD_TXD1  = 17;
   localparam int PAD_RXD0  = 18;
   localparam int PAD_TXD0  = 19;
   localparam int PAD_CTS1  = 20;
   localparam int PAD_RTS1  = 21;
   localparam int PAD_CTS0  = 22;
   localparam int PAD_RTS0  = 23;
   localparam int PAD_REQ2  = 24;
   localparam int PAD_REQ3  = 25;
   localparam int PAD_GNT1  = 26;
   localparam int PAD_GNT2  = 27;
   localparam int PAD_GNT3  = 28;
   localparam int PAD_PAR0  = 29;              // dedicated parallel bit 0

   // pad that carries each parallel port bit, bit 0 first
   localparam int PAR_PAD [PAR_W] = '{
      PAD_PAR0, PAD_RTS1, PAD_CTS1, PAD_TXD0, PAD_RXD0, PAD_TXD1, PAD_RXD1, PAD_DONE,
      PAD_DAK0, PAD_DRQ0, PAD_DAK1, PAD_DRQ1, PAD_DAK2, PAD_DRQ2, PAD_DAK3, PAD_DRQ3};

   // pin configuration register layout
   localparam int CFG_W          = 16;
   localparam int CFG_SEL_DMA0   = 0;          // dma pair 0 instead of parallel
   localparam int CFG_SEL_DMA1   = 1;
   localparam int CFG_SEL_DMA2   = 2;
   localparam int CFG_SEL_DMA3   = 3;
   localparam int CFG_SEL_TMR1   = 4;          // request 3 pad as timer output 1
   localparam int CFG_SEL_TMR0   = 5;          // acknowledge 3 pad as timer output 0
   localparam int CFG_SEL_TIMER_CLOCK_IN   = 6;          // request 2 pad as timer clock in
   localparam int CFG_SEL_DONE   = 7;          // done pad as dma done
   localparam int CFG_SEL_DNTMR  = 8;          // done pad as timer output 0
   localparam int CFG_SEL_SIO0   = 9;          // serial 0 data pair
   localparam int CFG_SEL_SIO1   = 10;         // serial 1 data pair
   localparam int CFG_SEL_HS1    = 11;         // serial 1 handshake pair
   localparam int CFG_SEL_SGRAM  = 12;         // rts 1 pad as sgram special function
   localparam int CFG_SEL_HS0    = 13;         // serial 0 handshake pair
   localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;

   // signals from the peripherals toward the pads
   typedef struct packed {
      logic [7:2]       sdram_chip_select;     // active low
      logic [7:2]       rom_chip_select;       // active low
      logic [7:2]       sdram_en;
      logic [7:2]       rom_en;
      logic [PAR_W-1:0] par_out;
      logic [PAR_W-1:0] par_oe;
      logic [3:0]       dma_ack_out;
      logic             done_out_n;
      logic             done_oe;
      logic [1:0]       timer_out;
      logic [1:0]       txd;
      logic [1:0]       rts_n;
      logic             sgram_special_function;
      logic             debug_serial_out;
      logic             trace_status_out;
      logic [3:0]       arb_gnt_n;
      logic             pci_req_n;
      logic             ext_arbiter_irq_out;
   } mpf_from_core_s;

   // signals from the pads toward the peripherals
   typedef struct packed {
      logic [PAR_W-1:0] par_in;
      logic [3:0]       dma_request_in;
      logic             done_in_n;
      logic             timer_clock_in;
      logic [1:0]       rxd;
      logic [1:0]       cts_n;
      logic [5:4]       irq_in;
      logic [3:0]       arb_req_n;
      logic             pci_gnt_n;
   } mpf_to_core_s;

   // inactive levels seen by every deselected peripheral input
   localparam mpf_to_core_s CORE_IDLE = '{
      par_in: 16'hFFFF, dma_request_in: 4'h0, done_in_n: 1'h1, timer_clock_in: 1'h0,
      rxd: 2'h3, cts_n: 2'h3, irq_in: 2'h3, arb_req_n: 4'hF, pci_gnt_n: 1'h1};

endpackage

// ===== rtl/mpf_sync.sv
// two flip-flop synchroniser for a vector of pad levels
// assumes each bit is an independent level; no reset so pad levels flow during reset
`timescale 1ns/100ps
module mpf_sync #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_ff;                      // first stage, read only by q

   // plain two-stage chain; nothing taps the first stage
   always_ff @(posedge clock) begin
      meta_ff <= d;
      q       <= meta_ff;
   end

endmodule

// ===== bench/mpf_pad_model.sv
// far side of the pads: external devices and pull-ups
// assumes pad_out/pad_oe of the pin mux; ext_level is what the far side drives
`timescale 1ns/100ps
module mpf_pad_model (
   input  wire logic [29:0] pad_out,
   input  wire logic [29:0] pad_oe,
   input  wire logic [29:0] ext_level,
   output logic      [29:0] pad_level
);
   // driven pads show the mux, released pads the far side or its pull-up
   always_comb begin
      for (int i = 0; i < 30; i++) begin
         pad_level[i] = pad_oe[i] ? pad_out[i] : ext_level[i];
      end
   end
endmodule

// ===== bench/tb_multiplexed_pin_function_select.sv
// self-checking bench for the pin mux, pads closed by the pad model
// assumes 10 MHz clock, inputs driven at the falling edge
`timescale 1ns/100ps
module tb_multiplexed_pin_function_select;
   logic                  clock, rst, dbg_n, strap, wr_en;
   logic [15:0]           wr_data, cfg;
   logic [29:0]           pin, pout, poe, ext;
   logic                  mode;
   mpf_pkg::mpf_from_core_s core;
   mpf_pkg::mpf_to_core_s   to_core;
   int                    n_fail, checks_done, cycles;

   mpf_pin_mux mpf_pin_mux_inst (.clock(clock), .rst(rst), .core_in(core), .core_out(to_core),
      .pad_in(pin), .pad_out(pout), .pad_oe(poe), .debugger_enable_n(dbg_n),
      .ext_arb_strap(strap), .cfg_wr_en(wr_en), .cfg_wr_data(wr_data),
      .pin_config_reg(cfg), .ext_arb_mode(mode));
   mpf_pad_model mpf_pad_model_inst (.pad_out(pout), .pad_oe(poe), .ext_level(ext),
      .pad_level(pin));

   // free-running clock, 100 ns period
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // hang guard, run needs about 56 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles > 1000) begin
         n_fail++;
         results();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(negedge clock);
   endtask

   // strap held through the whole reset so the mode capture sees it
   task automatic do_reset(input logic s);
      strap = s;
      rst = 1'b1;
      step(10);
      rst = 1'b0;
      step(1);
   endtask

   // one strobe, pads follow one edge after the register
   task automatic wr(input logic [15:0] d);
      wr_en = 1'b1;
      wr_data = d;
      step(1);
      wr_en = 1'b0;
      step(1);
   endtask

   initial begin
      rst = 1'b1; dbg_n = 1'b1; strap = 1'b0; wr_en = 1'b0; wr_data = 16'h0000;
      ext = '1; core = '0; core.sdram_chip_select = '1; core.rom_chip_select = '1;
      core.rts_n = '1; core.done_out_n = 1'b1; core.pci_req_n = 1'b1; core.arb_gnt_n = 4'hA;
      do_reset(1'b0);
      chk("cfg_rst", cfg, 16'h0000);
      chk("mode_int", mode, 1'b0);
      chk("idle_in", {to_core.timer_clock_in, to_core.dma_request_in}, 5'h00);
      chk("gnt0_out", {poe[4], pout[4]}, 2'b10);
      chk("req0_dir", poe[5], 1'b0);
      ext[5] = 1'b0; ext[22] = 1'b0; ext[29] = 1'b0;
      step(3);
      chk("req0_in", to_core.arb_req_n, 4'hE);
      chk("irq5", to_core.irq_in[5], 1'b0);
      chk("par0", to_core.par_in[0], 1'b0);
      ext = '1;
      // shared selects: sdram owner, rom owner, then both enabled
      core.sdram_en[3] = 1'b1; core.sdram_chip_select[3] = 1'b0; core.sdram_en[7] = 1'b1;
      core.sdram_chip_select[7] = 1'b0;
      step(1);
      chk("cs3_sdram", {poe[1], pout[1]}, 2'b10);
      chk("cs7", {poe[11], pout[11]}, 2'b10);
      core.sdram_en[3] = 1'b0; core.sdram_chip_select[3] = 1'b1;
      core.rom_en[3] = 1'b1; core.rom_chip_select[3] = 1'b0;
      step(1);
      chk("cs3_rom", {poe[1], pout[1]}, 2'b10);
      core.sdram_en[3] = 1'b1;
      step(1);
      chk("cs3_both", pout[1], 1'b0);
      // timer 1 on request 3 pad, then dma pair 3 overrides it
      core.timer_out = 2'b10;
      wr(16'h0010);
      chk("tmr1", {poe[7], pout[7]}, 2'b11);
      wr(16'h0018);
      step(1);
      chk("cfg_rd", cfg, 16'h0018);
      chk("drq3", {poe[7], to_core.dma_request_in[3]}, 2'b01);
      // debugger takes the serial 1 handshake pads
      // one extra cycle so the ownership check completes before the next reset
      core.debug_serial_out = 1'b1; core.trace_status_out = 1'b0; dbg_n = 1'b0;
      step(4);
      chk("dbg_pads", {poe[20], pout[20], poe[21], pout[21]}, 4'hE);
      dbg_n = 1'b1;
      // external arbiter mode
      do_reset(1'b1);
      chk("mode_ext", {mode, cfg}, 17'h10000);
      core.pci_req_n = 1'b0; core.ext_arbiter_irq_out = 1'b1; ext[4] = 1'b0;
      step(3);
      chk("req01_out", {poe[5], pout[5], poe[6], pout[6]}, 4'hB);
      chk("gnt0_in", {poe[4], to_core.pci_gnt_n}, 2'b00);
      chk("spare_req", poe[25:24], 2'b11);
      // done pad: timer 0 first, then dma done released and read back
      core.timer_out = 2'b01; core.done_oe = 1'b0; ext[15] = 1'b0;
      wr(16'h0180);
      chk("done_tmr", {poe[15], pout[15]}, 2'b11);
      wr(16'h0080);
      step(3);
      chk("done_in", {poe[15], to_core.done_in_n}, 2'b00);
      // serial 1 handshake by configuration: sgram on rts, cts as input
      core.sgram_special_function = 1'b0; ext[20] = 1'b0;
      wr(16'h1800);
      step(2);
      chk("hs1", {poe[21], pout[21], poe[20], to_core.cts_n[1]}, 4'h8);
      // serial 0 handshake selected: pads still reach the interrupt inputs
      ext[22] = 1'b0; core.rts_n[0] = 1'b0;
      wr(16'h2040);
      step(3);
      chk("hs0_timer_clock_in", {to_core.irq_in, to_core.cts_n[0], poe[23], pout[23],
         to_core.timer_clock_in}, 6'h05);
      results();
   end
endmodule
